// ===== gyro_regs_pkg.sv
// Constants for the dual-axis rate sensor register readout block.
// Assumes an 8-bit register space reached by a 16-bit-per-access serial port.
package gyro_regs_pkg;

  // ************************************************
  // Register addresses
  // ************************************************
  localparam logic [6:0] ADDR_X_RATE_LOW        = 7'h08;
  localparam logic [6:0] ADDR_X_RATE_HIGH       = 7'h09;
  localparam logic [6:0] ADDR_Y_RATE_LOW        = 7'h0a;
  localparam logic [6:0] ADDR_Y_RATE_HIGH       = 7'h0b;
  localparam logic [6:0] ADDR_TEMPERATURE_LOW   = 7'h0c;
  localparam logic [6:0] ADDR_TEMPERATURE_HIGH  = 7'h0d;
  localparam logic [6:0] ADDR_POWER_CONTROL     = 7'h10;
  localparam logic [6:0] ADDR_FILTER_POLE       = 7'h11;
  localparam logic [6:0] ADDR_PIN_FUNCTION      = 7'h12;

  // ************************************************
  // Field positions and reset values
  // ************************************************
  localparam int         TEMP_ENABLE_BIT        = 0;
  localparam int         MEASURE_BIT            = 1;
  localparam int         LOWPASS_LSB            = 0;
  localparam int         HIGHPASS_LSB           = 4;
  localparam logic [7:0] POWER_CONTROL_MASK     = 8'h03;
  localparam logic [7:0] FILTER_POLE_MASK       = 8'hf7;
  localparam logic [7:0] PIN_FUNCTION_MASK      = 8'h03;
  localparam logic [7:0] POWER_CONTROL_RESET    = 8'h00;
  localparam logic [7:0] FILTER_POLE_RESET      = 8'h00;
  localparam logic [7:0] PIN_FUNCTION_RESET     = 8'h00;
  localparam logic [1:0] PIN_FN_DATA_READY      = 2'h1;
  localparam int         PIN_FN_OUTPUT_BIT      = 0;
  localparam logic [15:0] RATE_RESET            = 16'h0000;
  localparam logic [11:0] TEMP_RESET            = 12'h000;

  // ************************************************
  // Serial framing
  // ************************************************
  localparam logic [2:0] LAST_BIT               = 3'h7;
  localparam logic       DIR_READ               = 1'b1;

  // Serial engine states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_HEADER = 3'b010,
    ST_DATA   = 3'b100
  } serial_state_t;

endpackage

// ===== gyro_rate_temp_register_readout.sv
// Register readout and control for a dual-axis angular rate sensor.
// Assumes sensor samples arrive on clk with one-cycle valid strobes, and the
// serial port pins come from an external host (synchronised here).
//
// Operation
// - X rate at first register pair, Y rate at following pair.
// - Lower address holds low byte, higher address high byte.
// - Rate bytes stay coherent for a whole multi-byte read burst.
// - Temperature is 12-bit; high register upper nibble reads zero.
// - Temperature and rate bytes are consistent across one burst.
// - Temperature code is ten counts per degree, zero means zero.
// - Power bit zero enables temperature sensor, reset off.
// - Power bit one selects measurement; bits seven to two read zero.
// - After reset the device stays in standby until host sets it.
// - Three-bit filter field selects the low-pass pole.
// - Four-bit upper filter field selects the high-pass pole.
// - Pin field 01 drives sync pin high while new data unread.
// - Pin field bit zero low samples sync pin as analog enable.
// - Transaction: direction bit, seven-bit address, eight-bit data.
// - In standby only single-register transactions are served.
`timescale 1ns/10ps
module gyro_rate_temp_register_readout
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        sclk_pin,
  input  wire logic        cs_n_pin,
  input  wire logic        sdi_pin,
  output logic             sdo_out,
  output logic             sdo_oe,
  input  wire logic        shared_event_pin_in,
  output logic             shared_event_pin_out,
  output logic             shared_event_pin_oe,
  input  wire logic [15:0] rate_x_in,
  input  wire logic [15:0] rate_y_in,
  input  wire logic        rate_valid,
  input  wire logic [11:0] temp_in,
  input  wire logic        temp_valid,
  output logic             measurement_mode,
  output logic             temp_sensor_enable,
  output logic [2:0]       lowpass_pole_select,
  output logic [3:0]       highpass_pole_select,
  output logic             analog_output_enable
);
  import gyro_regs_pkg::*;

  // ************************************************
  // Pin synchronisers
  // ************************************************
  logic [2:0] sclk_sync_reg;
  logic [2:0] cs_sync_reg;
  logic [1:0] sdi_sync_reg;
  logic [1:0] pin_sync_reg;
  // Stage 0 feeds stage 1 only; stage 2 is the edge-detect history
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_sync_reg <= 3'h7;
      cs_sync_reg   <= 3'h7;
      sdi_sync_reg  <= 2'h0;
      pin_sync_reg  <= 2'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_pin};
      cs_sync_reg   <= {cs_sync_reg[1:0], cs_n_pin};
      sdi_sync_reg  <= {sdi_sync_reg[0], sdi_pin};
      pin_sync_reg  <= {pin_sync_reg[0], shared_event_pin_in};
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;
  logic cs_start;
  logic sdi_bit;
  // Edges only from synchronised stages; 5 MHz serial clock leaves 2+ cycles per phase
  assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
  assign cs_active = ~cs_sync_reg[1];
  assign cs_start  = ~cs_sync_reg[1] & cs_sync_reg[2];
  assign sdi_bit   = sdi_sync_reg[1];

  // ************************************************
  // Decode helpers
  // ************************************************
  function automatic logic is_rate_addr(input logic [6:0] a);
    is_rate_addr = (a >= ADDR_X_RATE_LOW) && (a <= ADDR_Y_RATE_HIGH);
  endfunction

  logic [15:0] snap_x_reg;
  logic [15:0] snap_y_reg;
  logic [11:0] snap_temp_reg;
  logic [7:0]  power_reg;
  logic [7:0]  filter_reg;
  logic [7:0]  pin_fn_reg;
  // Data registers read from the burst snapshot, never the live sample
  function automatic logic [7:0] read_mux(input logic [6:0] a);
    case (a)
      ADDR_X_RATE_LOW:       read_mux = snap_x_reg[7:0];
      ADDR_X_RATE_HIGH:      read_mux = snap_x_reg[15:8];
      ADDR_Y_RATE_LOW:       read_mux = snap_y_reg[7:0];
      ADDR_Y_RATE_HIGH:      read_mux = snap_y_reg[15:8];
      ADDR_TEMPERATURE_LOW:  read_mux = snap_temp_reg[7:0];
      ADDR_TEMPERATURE_HIGH: read_mux = {4'h0, snap_temp_reg[11:8]};
      ADDR_POWER_CONTROL:    read_mux = power_reg;
      ADDR_FILTER_POLE:      read_mux = filter_reg;
      ADDR_PIN_FUNCTION:     read_mux = pin_fn_reg;
      default:               read_mux = 8'h00;
    endcase
  endfunction

  // ************************************************
  // Sample capture and snapshot
  // ************************************************
  logic [15:0] live_x_reg;
  logic [15:0] live_y_reg;
  logic [11:0] live_temp_reg;
  logic [15:0] live_x_next;
  logic [15:0] live_y_next;
  logic [11:0] live_temp_next;
  logic [15:0] snap_x_next;
  logic [15:0] snap_y_next;
  logic [11:0] snap_temp_next;
  // Live words follow the sensor; the snapshot is frozen while chip select is low
  always_comb begin
    live_x_next    = live_x_reg;
    live_y_next    = live_y_reg;
    live_temp_next = live_temp_reg;
    snap_x_next    = snap_x_reg;
    snap_y_next    = snap_y_reg;
    snap_temp_next = snap_temp_reg;
    if (rate_valid && power_reg[MEASURE_BIT]) begin
      live_x_next = rate_x_in;
      live_y_next = rate_y_in;
    end
    if (temp_valid && power_reg[TEMP_ENABLE_BIT]) begin
      live_temp_next = temp_in;
    end
    // One copy per frame keeps all six data bytes from the same instant
    if (cs_start) begin
      snap_x_next    = live_x_reg;
      snap_y_next    = live_y_reg;
      snap_temp_next = live_temp_reg;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      live_x_reg    <= RATE_RESET;
      live_y_reg    <= RATE_RESET;
      live_temp_reg <= TEMP_RESET;
      snap_x_reg    <= RATE_RESET;
      snap_y_reg    <= RATE_RESET;
      snap_temp_reg <= TEMP_RESET;
    end else begin
      live_x_reg    <= live_x_next;
      live_y_reg    <= live_y_next;
      live_temp_reg <= live_temp_next;
      snap_x_reg    <= snap_x_next;
      snap_y_reg    <= snap_y_next;
      snap_temp_reg <= snap_temp_next;
    end
  end

  // ************************************************
  // Serial engine
  // ************************************************
  serial_state_t state_reg;
  serial_state_t state_next;
  logic [2:0]    bit_cnt_reg;
  logic [2:0]    bit_cnt_next;
  logic [7:0]    rx_reg;
  logic [7:0]    rx_next;
  logic [7:0]    tx_reg;
  logic [7:0]    tx_next;
  logic [6:0]    addr_reg;
  logic [6:0]    addr_next;
  logic          dir_read_reg;
  logic          dir_read_next;
  logic          first_byte_reg;
  logic          first_byte_next;
  logic          sdo_next;
  logic          wr_en;
  logic [7:0]    wr_data;
  logic          rate_read_done;
  logic          byte_allowed;
  // Standby serves only the first data byte of a frame
  assign byte_allowed = first_byte_reg | power_reg[MEASURE_BIT];
  always_comb begin
    state_next      = state_reg;
    bit_cnt_next    = bit_cnt_reg;
    rx_next         = rx_reg;
    tx_next         = tx_reg;
    addr_next       = addr_reg;
    dir_read_next   = dir_read_reg;
    first_byte_next = first_byte_reg;
    sdo_next        = sdo_out;
    wr_en           = 1'b0;
    wr_data         = {rx_reg[6:0], sdi_bit};
    rate_read_done  = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        bit_cnt_next = 3'h0;
        if (cs_active) begin
          state_next = ST_HEADER;
        end
      end
      ST_HEADER: begin
        if (sclk_rise) begin
          rx_next      = {rx_reg[6:0], sdi_bit};
          bit_cnt_next = bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == LAST_BIT) begin
            // Direction bit first, then seven address bits
            dir_read_next   = (rx_reg[6] == DIR_READ);
            addr_next       = {rx_reg[5:0], sdi_bit};
            tx_next         = read_mux({rx_reg[5:0], sdi_bit});
            first_byte_next = 1'b1;
            state_next      = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        // Host samples on rising edge, so data moves on the falling edge
        if (sclk_fall && dir_read_reg) begin
          sdo_next = tx_reg[7];
          tx_next  = {tx_reg[6:0], 1'b0};
        end
        if (sclk_rise) begin
          rx_next      = {rx_reg[6:0], sdi_bit};
          bit_cnt_next = bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == LAST_BIT) begin
            wr_en           = ~dir_read_reg & byte_allowed;
            rate_read_done  = dir_read_reg & byte_allowed & is_rate_addr(addr_reg);
            first_byte_next = 1'b0;
            // Bursts walk the address upward; standby returns zeros instead
            addr_next = addr_reg + 7'h1;
            tx_next   = power_reg[MEASURE_BIT] ? read_mux(addr_reg + 7'h1) : 8'h00;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // Chip select release aborts any partial byte
    if (!cs_active) begin
      state_next = ST_IDLE;
      sdo_next   = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg      <= ST_IDLE;
      bit_cnt_reg    <= 3'h0;
      rx_reg         <= 8'h00;
      tx_reg         <= 8'h00;
      addr_reg       <= 7'h00;
      dir_read_reg   <= 1'b0;
      first_byte_reg <= 1'b0;
      sdo_out        <= 1'b0;
      sdo_oe         <= 1'b0;
    end else begin
      state_reg      <= state_next;
      bit_cnt_reg    <= bit_cnt_next;
      rx_reg         <= rx_next;
      tx_reg         <= tx_next;
      addr_reg       <= addr_next;
      dir_read_reg   <= dir_read_next;
      first_byte_reg <= first_byte_next;
      sdo_out        <= sdo_next;
      sdo_oe         <= (state_next == ST_DATA) & dir_read_next;
    end
  end

  // ************************************************
  // Control registers and data-ready
  // ************************************************
  logic [7:0] power_next;
  logic [7:0] filter_next;
  logic [7:0] pin_fn_next;
  logic       data_ready_reg;
  logic       data_ready_next;
  logic       newer_reg;
  logic       newer_next;
  always_comb begin
    power_next  = power_reg;
    filter_next = filter_reg;
    pin_fn_next = pin_fn_reg;
    if (wr_en) begin
      case (addr_reg)
        ADDR_POWER_CONTROL: power_next  = wr_data & POWER_CONTROL_MASK;
        ADDR_FILTER_POLE:   filter_next = wr_data & FILTER_POLE_MASK;
        ADDR_PIN_FUNCTION:  pin_fn_next = wr_data & PIN_FUNCTION_MASK;
        default:            power_next  = power_reg;
      endcase
    end
    // A fresh sample landing with the clearing read wins, so no update is lost
    data_ready_next = data_ready_reg;
    // A sample newer than this frame's snapshot stays flagged until a later frame reads it
    newer_next      = newer_reg & ~cs_start;
    if (rate_read_done && !newer_reg) begin
      data_ready_next = 1'b0;
    end
    if (rate_valid && power_reg[MEASURE_BIT]) begin
      data_ready_next = 1'b1;
      newer_next      = 1'b1;
    end
  end

  // Reset leaves standby selected and the temperature sensor off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      power_reg      <= POWER_CONTROL_RESET;
      filter_reg     <= FILTER_POLE_RESET;
      pin_fn_reg     <= PIN_FUNCTION_RESET;
      data_ready_reg <= 1'b0;
      newer_reg      <= 1'b0;
      measurement_mode     <= 1'b0;
      temp_sensor_enable   <= 1'b0;
      lowpass_pole_select  <= 3'h0;
      highpass_pole_select <= 4'h0;
      shared_event_pin_out <= 1'b0;
      shared_event_pin_oe  <= 1'b0;
      analog_output_enable <= 1'b0;
    end else begin
      power_reg      <= power_next;
      filter_reg     <= filter_next;
      pin_fn_reg     <= pin_fn_next;
      data_ready_reg <= data_ready_next;
      newer_reg      <= newer_next;
      measurement_mode     <= power_next[MEASURE_BIT];
      temp_sensor_enable   <= power_next[TEMP_ENABLE_BIT];
      lowpass_pole_select  <= filter_next[LOWPASS_LSB +: 3];
      highpass_pole_select <= filter_next[HIGHPASS_LSB +: 4];
      // Pattern 11 is undefined; the pin is left undriven then
      shared_event_pin_oe  <= (pin_fn_next == PIN_FN_DATA_READY);
      shared_event_pin_out <= (pin_fn_next == PIN_FN_DATA_READY) & data_ready_next;
      analog_output_enable <= ~pin_fn_next[PIN_FN_OUTPUT_BIT] & pin_sync_reg[1];
    end
  end

endmodule // gyro_rate_temp_register_readout

// ===== gyro_readout_sva.sv
// Checker for the rate sensor register readout, watching top-level ports.
// Assumes the host holds chip-select low a few clocks past the last edge.
`timescale 1ns/10ps
module gyro_readout_sva (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       cs_n_pin,
  input wire logic       sdo_oe,
  input wire logic       shared_event_pin_in,
  input wire logic       shared_event_pin_out,
  input wire logic       shared_event_pin_oe,
  input wire logic       rate_valid,
  input wire logic       measurement_mode,
  input wire logic       temp_sensor_enable,
  input wire logic [2:0] lowpass_pole_select,
  input wire logic [3:0] highpass_pole_select,
  input wire logic       analog_output_enable
);
  // ********************
  // Port relations
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Control bits only move while a host frame is open
  property p_mode_in_frame; $rose(measurement_mode) |-> !$past(cs_n_pin); endproperty
  a_mode_in_frame: assert property (p_mode_in_frame) else $error("Mode set outside a frame");
  property p_tse_in_frame; $changed(temp_sensor_enable) |-> !$past(cs_n_pin); endproperty
  a_tse_in_frame: assert property (p_tse_in_frame) else $error("Sensor enable moved outside a frame");
  property p_pole_in_frame;
    $changed({highpass_pole_select, lowpass_pole_select}) |-> !$past(cs_n_pin);
  endproperty
  a_pole_in_frame: assert property (p_pole_in_frame) else $error("Pole select moved outside a frame");
  // Ready level is only shown while the pin is an output
  property p_ready_driven; shared_event_pin_out |-> shared_event_pin_oe; endproperty
  a_ready_driven: assert property (p_ready_driven) else $error("Ready high while pin released");
  property p_ready_set;
    rate_valid && measurement_mode && shared_event_pin_oe |-> ##[1:2] shared_event_pin_out;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("Ready not raised after new sample");
  // Ready only drops through a host access
  property p_ready_clear; $fell(shared_event_pin_out) |-> !$past(cs_n_pin, 2); endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("Ready dropped without a read");
  property p_analog_gate; analog_output_enable |-> !shared_event_pin_oe; endproperty
  a_analog_gate: assert property (p_analog_gate) else $error("Analog enable while pin driven");
  property p_analog_src; $rose(analog_output_enable) |-> $past(shared_event_pin_in); endproperty
  a_analog_src: assert property (p_analog_src) else $error("Analog enable without pin high");
  // Read data drive is confined to the selected frame
  property p_sdo_in_frame; $rose(sdo_oe) |-> !cs_n_pin; endproperty
  a_sdo_in_frame: assert property (p_sdo_in_frame) else $error("Data drive outside a frame");
  property p_sdo_release; $rose(cs_n_pin) |-> ##[1:6] !sdo_oe; endproperty
  a_sdo_release: assert property (p_sdo_release) else $error("Data drive held after deselect");
endmodule // gyro_readout_sva

// ===== spi_host_model.sv
// Host model for the sensor serial port: mode 3 frames, MSB first.
// Assumes the sensor synchronises the pins; runs on its own timing.
`timescale 1ns/10ps
module spi_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  localparam int HALF = 240; // Slower than the 200 ns minimum period
  // Idle: clock high, deselected
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    sdi  = 1'b1;
  end
  // Header then n bytes; bursts are used for coherent samples
  task automatic xfer(input logic rw, input logic [6:0] a, input int n, inout logic [7:0] d [6]);
    logic [7:0] sh;
    cs_n = 1'b0;
    #(HALF);
    for (int b = 0; b <= n; b++) begin
      sh = (b == 0) ? {rw, a} : d[b-1];
      for (int i = 7; i >= 0; i--) begin
        sclk  = 1'b0;
        sdi   = sh[i];
        #(HALF);
        sclk  = 1'b1;
        sh[i] = sdo;
        #(HALF);
      end
      if (b > 0 && rw) d[b-1] = sh;
    end
    #(2 * HALF); // Quiet time before deselect
    cs_n = 1'b1;
    sdi  = ~sdi; // Stale level is not kept on a released line
    #(2 * HALF);
  endtask
endmodule // spi_host_model

// ===== tb.sv
// Self-checking bench for the rate sensor register readout.
// Assumes the host model and the checker are compiled alongside.
`timescale 1ns/10ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fails++; $display("Error %s expected %h seen %h", n, e, a); end end
module tb;
  import gyro_regs_pkg::*;
  logic        clk = 0, nrst = 0, ev_in = 0, rv = 0, tv = 0;
  logic [15:0] rx = '0, ry = '0;
  logic [11:0] tin = '0;
  logic        sclk, cs_n, sdi, sdo, sdo_oe, ev_out, ev_oe, mm, tse, aoe;
  logic [2:0]  lp;
  logic [3:0]  hp;
  logic [7:0]  d [6];
  logic [7:0]  exp_b [6] = '{8'h01, 8'h80, 8'hfe, 8'h7f, 8'h9c, 8'h0f};
  int          fails = 0, tests_run = 0, cyc = 0;

  always #20 clk = ~clk;

  spi_host_model host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
  gyro_rate_temp_register_readout uut (
    .clk(clk), .nrst(nrst), .sclk_pin(sclk), .cs_n_pin(cs_n), .sdi_pin(sdi), .sdo_out(sdo),
    .sdo_oe(sdo_oe), .shared_event_pin_in(ev_in), .shared_event_pin_out(ev_out),
    .shared_event_pin_oe(ev_oe), .rate_x_in(rx), .rate_y_in(ry), .rate_valid(rv), .temp_in(tin),
    .temp_valid(tv), .measurement_mode(mm), .temp_sensor_enable(tse), .lowpass_pole_select(lp),
    .highpass_pole_select(hp), .analog_output_enable(aoe));

  // ********************
  // Shared tasks
  // ********************
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    d[0] = v;
    host.xfer(1'b0, a, 1, d);
  endtask
  task automatic rd_chk(input string n, input logic [6:0] a, input logic [7:0] e);
    host.xfer(1'b1, a, 1, d);
    `CHK(n, e, d[0])
  endtask
  // One sample of every sensor input, single-cycle strobes
  task automatic sample(input logic [15:0] x, input logic [15:0] y, input logic [11:0] t);
    @(posedge clk) #1 {rx, ry, tin, rv, tv} = {x, y, t, 2'b11};
    @(posedge clk) #1 {rv, tv} = 2'b00;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic t_reset();
    `CHK("mode", 1'b0, mm)
    `CHK("tsense", 1'b0, tse)
    rd_chk("power", ADDR_POWER_CONTROL, 8'h00);
    rd_chk("filter", ADDR_FILTER_POLE, 8'h00);
    rd_chk("pinfn", ADDR_PIN_FUNCTION, 8'h00);
  endtask
  // Reserved bits, read-only and unmapped places
  task automatic t_regs();
    wr(ADDR_POWER_CONTROL, 8'hff);
    rd_chk("power", ADDR_POWER_CONTROL, 8'h03);
    `CHK("mode", 1'b1, mm)
    `CHK("tsense", 1'b1, tse)
    wr(ADDR_FILTER_POLE, 8'hff);
    rd_chk("filter", ADDR_FILTER_POLE, 8'hf7);
    `CHK("lowpass", 3'h7, lp)
    `CHK("highpass", 4'hf, hp)
    wr(ADDR_X_RATE_LOW, 8'h55);
    rd_chk("ro", ADDR_X_RATE_LOW, 8'h00);
    rd_chk("unmapped", 7'h20, 8'h00);
  endtask
  // Burst with a new sample arriving mid-burst
  task automatic t_data();
    wr(ADDR_PIN_FUNCTION, 8'h01);
    `CHK("pin_oe", 1'b1, ev_oe)
    sample(16'h8001, 16'h7ffe, 12'hf9c); // -10 degC
    `CHK("ready", 1'b1, ev_out)
    fork
      host.xfer(1'b1, ADDR_X_RATE_LOW, 6, d);
      begin
        #6000;
        sample(16'h1234, 16'h0000, 12'h0fa);
      end
    join
    for (int i = 0; i < 6; i++) `CHK("burst", exp_b[i], d[i])
    // The mid-burst sample is newer than the burst's snapshot, so it stays flagged
    `CHK("ready", 1'b1, ev_out)
    rd_chk("xlow", ADDR_X_RATE_LOW, 8'h34);
    `CHK("ready", 1'b0, ev_out)
  endtask
  task automatic t_analog();
    wr(ADDR_PIN_FUNCTION, 8'h00);
    ev_in = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    `CHK("aen", 1'b1, aoe)
    wr(ADDR_PIN_FUNCTION, 8'h02);
    `CHK("aen", 1'b1, aoe)
    `CHK("pin_oe", 1'b0, ev_oe)
    wr(ADDR_PIN_FUNCTION, 8'h01);
    `CHK("aen", 1'b0, aoe)
    ev_in = 1'b0;
  endtask
  // Sensor off: temperature holds its last code while rates still update
  task automatic t_tsense();
    wr(ADDR_POWER_CONTROL, 8'h02);
    sample(16'h00aa, 16'h0000, 12'h123);
    rd_chk("temp_hold", ADDR_TEMPERATURE_LOW, 8'hfa);
    rd_chk("x_new", ADDR_X_RATE_LOW, 8'haa);
  endtask
  // Standby refuses bytes past the first
  task automatic t_standby();
    wr(ADDR_POWER_CONTROL, 8'h01);
    host.xfer(1'b1, ADDR_POWER_CONTROL, 2, d);
    `CHK("first", 8'h01, d[0])
    `CHK("second", 8'h00, d[1])
  endtask

  task automatic stop_test();
    $display("Checks %0d, errors %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard, well above the expected few thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    t_reset();
    t_regs();
    t_data();
    t_analog();
    t_tsense();
    t_standby();
    stop_test();
  end
endmodule // tb

bind gyro_rate_temp_register_readout gyro_readout_sva chk (
  .clk(clk), .nrst(nrst), .cs_n_pin(cs_n_pin), .sdo_oe(sdo_oe), .shared_event_pin_in(shared_event_pin_in),
  .shared_event_pin_out(shared_event_pin_out), .shared_event_pin_oe(shared_event_pin_oe),
  .rate_valid(rate_valid), .measurement_mode(measurement_mode), .temp_sensor_enable(temp_sensor_enable),
  .lowpass_pole_select(lowpass_pole_select), .highpass_pole_select(highpass_pole_select),
  .analog_output_enable(analog_output_enable));
